// [design/t16w_timer.v]
// Purpose: 16-bit timer with waveform mode and two compare output channels
// Assumes: pins async to clk_sys; port direction and data bits from same clock
// Notes: registers over Avalon-MM, one wait cycle on every access
`timescale 1ns/1ps
`default_nettype none
`include "t16w_map.vh"

// What this block does
// - all logic on clk_sys; selected timer clock is only a one-cycle enable
// - phase-and-frequency-correct modes reload compares at BOTTOM, other PWM modes at TOP
// - nonzero output-mode field routes waveform to pin, save 01 in PWM modes other than 9 and 15 on channel A; driver enabled by direction bit
// - non-PWM: 00 off, 01 toggle, 10 low, 11 high on compare match
// - fast PWM 01 toggles channel A only in mode 15, else disconnected
// - fast PWM 10 clears on match, sets at TOP; 11 the inverse
// - fast PWM compare equal to TOP with upper bit set: TOP action wins
// - dual-slope 01 toggles channel A only in mode 9
// - dual-slope 10 clears on up match, sets on down match; 11 inverse
// - force strobes act only in non-PWM modes
// - force strobe applies match action immediately using the output mode written with it
// - forced match sets no flag and never clears the counter
// - force bit positions always read zero
// - mode is two low bits in control a plus two high in control b
// - mode 0 normal to 0xFFFF; 4 and 12 clear on match; immediate; flag at MAX
// - modes 1-3,10,11 phase correct; reload at TOP; overflow at BOTTOM
// - modes 8,9 phase-and-frequency correct; reload and overflow at BOTTOM
// - modes 5-7,14,15 fast PWM; reload and overflow at TOP
// - clock select: stopped, divide 1/8/64/256/1024, external falling or rising
// - counter write blocks compare match on the next timer tick
// - capture disabled while capture register serves as TOP
module t16w_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // pins
  input  wire        extClockPin,
  input  wire        capturePin,
  // port logic for the two waveform pins
  input  wire        portDataA,
  input  wire        portDataB,
  input  wire        portDirA,
  input  wire        portDirB,
  output reg         padA,
  output reg         padAOen_n,
  output reg         padB,
  output reg         padBOen_n
);

  // mode classes, one-hot
  localparam [4:0] CL_NORM = 5'h01;
  localparam [4:0] CL_CTC  = 5'h02;
  localparam [4:0] CL_FAST = 5'h04;
  localparam [4:0] CL_PC   = 5'h08;
  localparam [4:0] CL_PFC  = 5'h10;

  // classify the 4-bit waveform mode
  function [4:0] modeClass;
    input [3:0] m;
    begin
      case (m)
        4'h1, 4'h2, 4'h3, 4'ha, 4'hb: modeClass = CL_PC;
        4'h4, 4'hc:                   modeClass = CL_CTC;
        4'h5, 4'h6, 4'h7, 4'he, 4'hf: modeClass = CL_FAST;
        4'h8, 4'h9:                   modeClass = CL_PFC;
        default:                      modeClass = CL_NORM;
      endcase
    end
  endfunction

  // top value of each mode
  function [15:0] topOf;
    input [3:0]  m;
    input [15:0] cmpA;
    input [15:0] capt;
    begin
      case (m)
        4'h1, 4'h5:             topOf = `T16W_TOP_8BIT;
        4'h2, 4'h6:             topOf = `T16W_TOP_9BIT;
        4'h3, 4'h7:             topOf = `T16W_TOP_10BIT;
        4'h4, 4'h9, 4'hb, 4'hf: topOf = cmpA;
        4'h8, 4'ha, 4'hc, 4'he: topOf = capt;
        default:                topOf = `T16W_MAX;
      endcase
    end
  endfunction

  // next waveform bit for one channel
  function waveNext;
    input [4:0] cls;
    input [1:0] com;
    input       isA;
    input [3:0] m;
    input       match;
    input       atTop;
    input       up;
    input       cur;
    begin
      waveNext = cur;
      case (cls)
        CL_FAST: begin
          if (com == 2'b01) begin
            if (isA && m == 4'hf && match)
              waveNext = ~cur;
          end else if (com[1]) begin
            if (atTop)
              waveNext = ~com[0];
            else if (match)
              waveNext = com[0];
          end
        end
        CL_PC, CL_PFC: begin
          if (com == 2'b01) begin
            if (isA && (m == 4'h9 || m == 4'he) && match)
              waveNext = ~cur;
          end else if (com[1] && match) begin
            waveNext = up ? com[0] : ~com[0];
          end
        end
        default: begin
          if (match) begin
            case (com)
              2'b01:   waveNext = ~cur;
              2'b10:   waveNext = 1'b0;
              2'b11:   waveNext = 1'b1;
              default: waveNext = cur;
            endcase
          end
        end
      endcase
    end
  endfunction

  // software-visible state
  reg  [1:0]  comA;
  reg  [1:0]  comB;
  reg  [1:0]  wgmLow;
  reg  [1:0]  wgmHigh;
  reg         noiseCancel;
  reg         edgeRise;
  reg  [2:0]  clockSelect;
  reg  [15:0] count;
  reg  [15:0] cmpBufA;
  reg  [15:0] cmpBufB;
  reg  [15:0] cmpA;
  reg  [15:0] cmpB;
  reg  [15:0] capture;
  reg  [3:0]  flags;
  // internal state
  reg         countDown;
  reg         blockMatch;
  reg         waveA;
  reg         waveB;
  reg  [9:0]  prescale;
  reg         extSync1;
  reg         extSync2;
  reg         extPrev;
  reg         capSync1;
  reg         capSync2;
  reg         capPrev;
  reg         tick;
  reg  [31:0] rdMux;
  reg  [3:0]  flagSet;

  wire [3:0]  mode = {wgmHigh, wgmLow};
  wire [4:0]  cls = modeClass(mode);
  wire [15:0] top = topOf(mode, cmpA, capture);
  wire        isPwm = (cls != CL_NORM) && (cls != CL_CTC);
  wire        dual = (cls == CL_PC) || (cls == CL_PFC);
  wire        wrStb = write && !waitrequest;
  wire        wrCtrlA = wrStb && address == `T16W_OFF_CTRL_A;
  wire        atTop = (count == top);
  wire        atBottom = countDown && (count == `T16W_RST_WORD);
  wire        matchA = tick && !blockMatch && (count == cmpA);
  wire        matchB = tick && !blockMatch && (count == cmpB);
  wire        captTop = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
  wire        forceA = wrCtrlA && writedata[`T16W_CA_FORCE_A] && !isPwm;
  wire        forceB = wrCtrlA && writedata[`T16W_CA_FORCE_B] && !isPwm;
  wire [1:0]  newComA = writedata[`T16W_CA_COMA_HI:`T16W_CA_COMA_LO];
  wire [1:0]  newComB = writedata[`T16W_CA_COMB_HI:`T16W_CA_COMB_LO];
  wire        immUpdate = (cls == CL_NORM) || (cls == CL_CTC);
  // reload point: TOP in fast pwm and phase correct, BOTTOM in phase-and-frequency correct
  wire        reload = tick && ((cls == CL_PFC) ? atBottom : (isPwm && atTop && !countDown));
  wire        capEdge = edgeRise ? (capSync2 && !capPrev) : (!capSync2 && capPrev);

  // input synchronisers, the first stage feeds only the second
  always @(posedge clk_sys) begin
    if (!rstn) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
      capSync1 <= 1'b0;
      capSync2 <= 1'b0;
      capPrev  <= 1'b0;
    end else begin
      extSync1 <= extClockPin;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
      capSync1 <= capturePin;
      capSync2 <= capSync1;
      capPrev  <= capSync2;
    end
  end

  // prescaler and tick select; tick is a one-cycle enable, never a clock
  always @(posedge clk_sys) begin
    if (!rstn) begin
      prescale <= 10'h000;
      tick     <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      case (clockSelect)
        3'h1:    tick <= 1'b1;
        3'h2:    tick <= (prescale[2:0] == 3'h7);
        3'h3:    tick <= (prescale[5:0] == 6'h3f);
        3'h4:    tick <= (prescale[7:0] == 8'hff);
        3'h5:    tick <= (prescale == 10'h3ff);
        3'h6:    tick <= !extSync2 && extPrev;
        3'h7:    tick <= extSync2 && !extPrev;
        default: tick <= 1'b0;
      endcase
    end
  end

  // event sources for the flag register; forced matches never land here
  always @* begin
    flagSet = 4'h0;
    flagSet[`T16W_FL_CMP_A] = matchA;
    flagSet[`T16W_FL_CMP_B] = matchB;
    flagSet[`T16W_FL_CAPT]  = capEdge && !captTop;
    if (tick) begin
      if (immUpdate)
        flagSet[`T16W_FL_OVF] = (count == `T16W_MAX);
      else if (cls == CL_FAST)
        flagSet[`T16W_FL_OVF] = atTop;
      else
        flagSet[`T16W_FL_OVF] = atBottom;
    end
  end

  // register read mux; unmapped offsets read zero
  always @* begin
    rdMux = 32'h00000000;
    case (address)
      `T16W_OFF_CTRL_A:  rdMux[7:0] = {comA, comB, 2'b00, wgmLow};
      `T16W_OFF_CTRL_B:  rdMux[7:0] = {noiseCancel, edgeRise, 1'b0, wgmHigh, clockSelect};
      `T16W_OFF_COUNT:   rdMux[15:0] = count;
      `T16W_OFF_CMP_A:   rdMux[15:0] = cmpBufA;
      `T16W_OFF_CMP_B:   rdMux[15:0] = cmpBufB;
      `T16W_OFF_CAPTURE: rdMux[15:0] = capture;
      `T16W_OFF_FLAGS:   rdMux[3:0] = flags;
      default:           rdMux = 32'h00000000;
    endcase
  end

  // bus handshake: one wait cycle, data stands while waitrequest is low
  always @(posedge clk_sys) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= read ? rdMux : 32'h00000000;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // control registers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      comA        <= 2'b00;
      comB        <= 2'b00;
      wgmLow      <= 2'b00;
      wgmHigh     <= 2'b00;
      noiseCancel <= 1'b0;
      edgeRise    <= 1'b0;
      clockSelect <= 3'h0;
    end else if (wrStb) begin
      if (address == `T16W_OFF_CTRL_A) begin
        comA   <= newComA;
        comB   <= newComB;
        wgmLow <= writedata[`T16W_CA_WGM_HI:`T16W_CA_WGM_LO];
      end
      if (address == `T16W_OFF_CTRL_B) begin
        noiseCancel <= writedata[`T16W_CB_NOISE];
        edgeRise    <= writedata[`T16W_CB_EDGE];
        wgmHigh     <= writedata[`T16W_CB_WGM_HI:`T16W_CB_WGM_LO];
        clockSelect <= writedata[`T16W_CB_CS_HI:`T16W_CB_CS_LO];
      end
    end
  end

  // compare buffers and active compares, plus capture register
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cmpBufA <= `T16W_RST_WORD;
      cmpBufB <= `T16W_RST_WORD;
      cmpA    <= `T16W_RST_WORD;
      cmpB    <= `T16W_RST_WORD;
      capture <= `T16W_RST_WORD;
    end else begin
      if (wrStb && address == `T16W_OFF_CMP_A)
        cmpBufA <= writedata[15:0];
      if (wrStb && address == `T16W_OFF_CMP_B)
        cmpBufB <= writedata[15:0];
      // immediate modes track the buffer, others wait for the reload point
      if (immUpdate || reload) begin
        cmpA <= cmpBufA;
        cmpB <= cmpBufB;
      end
      if (wrStb && address == `T16W_OFF_CAPTURE)
        capture <= writedata[15:0];
      else if (capEdge && !captTop)
        capture <= count;
    end
  end

  // counter: software write wins over a tick and blocks the next match
  always @(posedge clk_sys) begin
    if (!rstn) begin
      count      <= `T16W_RST_WORD;
      countDown  <= 1'b0;
      blockMatch <= 1'b0;
    end else if (wrStb && address == `T16W_OFF_COUNT) begin
      count      <= writedata[15:0];
      blockMatch <= 1'b1;
    end else if (tick) begin
      blockMatch <= 1'b0;
      if (!dual) begin
        countDown <= 1'b0;
        // forced matches do not reach here, so they never clear the count
        if (cls != CL_NORM && atTop)
          count <= `T16W_RST_WORD;
        else
          count <= count + 16'h0001;
      end else if (!countDown) begin
        if (count >= top) begin
          countDown <= 1'b1;
          count     <= count - 16'h0001;
        end else begin
          count <= count + 16'h0001;
        end
      end else if (count == `T16W_RST_WORD) begin
        countDown <= 1'b0;
        count     <= count + 16'h0001;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  // waveform bits; a force uses the output mode written with it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      waveA <= 1'b0;
      waveB <= 1'b0;
    end else begin
      if (forceA)
        waveA <= waveNext(CL_NORM, newComA, 1'b1, mode, 1'b1, 1'b0, 1'b1, waveA);
      else if (tick)
        waveA <= waveNext(cls, comA, 1'b1, mode, matchA, atTop, !countDown, waveA);
      if (forceB)
        waveB <= waveNext(CL_NORM, newComB, 1'b0, mode, 1'b1, 1'b0, 1'b1, waveB);
      else if (tick)
        waveB <= waveNext(cls, comB, 1'b0, mode, matchB, atTop, !countDown, waveB);
    end
  end

  // flags: a new event wins over a same-cycle clear
  always @(posedge clk_sys) begin
    if (!rstn)
      flags <= 4'h0;
    else if (wrStb && address == `T16W_OFF_FLAGS)
      flags <= (flags & ~writedata[3:0]) | flagSet;
    else
      flags <= flags | flagSet;
  end

  // pin mux: output mode takes the pin, except a 01 that disconnects in pwm modes other than 9 and 15 on pad a
  always @(posedge clk_sys) begin
    if (!rstn) begin
      padA      <= 1'b0;
      padB      <= 1'b0;
      padAOen_n <= 1'b1;
      padBOen_n <= 1'b1;
    end else begin
      padA      <= (comA[1] || (comA[0] && (!isPwm || mode == 4'hf || mode == 4'h9))) ? waveA : portDataA;
      padB      <= (comB[1] || (comB[0] && !isPwm)) ? waveB : portDataB;
      padAOen_n <= !portDirA;
      padBOen_n <= !portDirB;
    end
  end

endmodule
`default_nettype wire

// [design/t16w_map.vh]
// Purpose: register map, field positions and reset values of the 16-bit timer
// Assumes: 32-bit Avalon-MM slave, one aligned word per register
// Notes: definitions only
`ifndef T16W_MAP_VH
`define T16W_MAP_VH
// byte offsets
`define T16W_OFF_CTRL_A   5'h00
`define T16W_OFF_CTRL_B   5'h04
`define T16W_OFF_COUNT    5'h08
`define T16W_OFF_CMP_A    5'h0c
`define T16W_OFF_CMP_B    5'h10
`define T16W_OFF_CAPTURE  5'h14
`define T16W_OFF_FLAGS    5'h18
// control a fields
`define T16W_CA_COMA_HI   7
`define T16W_CA_COMA_LO   6
`define T16W_CA_COMB_HI   5
`define T16W_CA_COMB_LO   4
`define T16W_CA_FORCE_A   3
`define T16W_CA_FORCE_B   2
`define T16W_CA_WGM_HI    1
`define T16W_CA_WGM_LO    0
// control b fields
`define T16W_CB_NOISE     7
`define T16W_CB_EDGE      6
`define T16W_CB_WGM_HI    4
`define T16W_CB_WGM_LO    3
`define T16W_CB_CS_HI     2
`define T16W_CB_CS_LO     0
// flag bits, write one to clear
`define T16W_FL_OVF       0
`define T16W_FL_CMP_B     1
`define T16W_FL_CMP_A     2
`define T16W_FL_CAPT      3
// reset values
`define T16W_RST_CTRL     8'h00
`define T16W_RST_WORD     16'h0000
// fixed top values and max
`define T16W_TOP_8BIT     16'h00ff
`define T16W_TOP_9BIT     16'h01ff
`define T16W_TOP_10BIT    16'h03ff
`define T16W_MAX          16'hffff
`endif

// [test/t16w_timer_sva.sv]
// Purpose: bus and pin checks for the timer
// Assumes: control fields rebuilt from bus writes
// Notes: force checks only hold with the clock stopped
`timescale 1ns/1ps
`default_nettype none
module t16w_timer_sva (
  // clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // bus
  input wire [4:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // pins
  input wire        portDataA,
  input wire        portDataB,
  input wire        portDirA,
  input wire        portDirB,
  input wire        padA,
  input wire        padAOen_n,
  input wire        padB,
  input wire        padBOen_n
);
  reg  [7:0] ctrlA;
  reg  [4:0] ctrlB;
  wire       wrDone = write && !waitrequest;
  wire [3:0] curMode = {ctrlB[4:3], ctrlA[1:0]};
  // force is judged on the mode in force before the write; a running tick could also move the bit
  wire       forceOk = wrDone && address == 5'h00 && ctrlB[2:0] == 3'h0 &&
                       (curMode == 4'h0 || curMode == 4'h4 || curMode == 4'hc || curMode == 4'hd);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // shadow of the control fields
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrlA <= 8'h00;
      ctrlB <= 5'h00;
    end else if (wrDone && address == 5'h00) begin
      ctrlA <= writedata[7:0];
    end else if (wrDone && address == 5'h04) begin
      ctrlB <= writedata[4:0];
    end
  end
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait cycle");
  AST_WAIT_SHORT: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  AST_OEN_A: assert property ($past(rstn) |-> padAOen_n == !$past(portDirA))
    else $error("pad a enable does not follow direction");
  AST_OEN_B: assert property ($past(rstn) |-> padBOen_n == !$past(portDirB))
    else $error("pad b enable does not follow direction");
  AST_PAD_PORT_A: assert property ($past(rstn) && ctrlA[7:6] == 2'b00 && $past(ctrlA[7:6]) == 2'b00 |-> padA == $past(portDataA))
    else $error("pad a not on port data while disconnected");
  AST_PAD_PORT_B: assert property ($past(rstn) && ctrlA[5:4] == 2'b00 && $past(ctrlA[5:4]) == 2'b00 |-> padB == $past(portDataB))
    else $error("pad b not on port data while disconnected");
  AST_FORCE_SET_A: assert property (forceOk && writedata[7:6] == 2'b11 && writedata[3] |-> ##2 padA)
    else $error("forced set on a not seen");
  AST_FORCE_CLR_B: assert property (forceOk && writedata[5:4] == 2'b10 && writedata[2] |-> ##2 !padB)
    else $error("forced clear on b not seen");
  AST_RD_FORCE_ZERO: assert property (read && !waitrequest && address == 5'h00 |-> readdata[3:2] == 2'b00)
    else $error("force bits read nonzero");
  AST_RD_CTRL_A: assert property (read && !waitrequest && address == 5'h00 |-> readdata[7:4] == ctrlA[7:4] && readdata[1:0] == ctrlA[1:0])
    else $error("control a readback wrong");
  COV_FORCE: cover property (forceOk && writedata[3]);
  COV_PWM_PAD: cover property ($rose(padA) && ctrlB[2:0] != 3'h0);
  COV_RD_CTRL: cover property (read && !waitrequest && address == 5'h00);
endmodule
bind t16w_timer t16w_timer_sva chk (
  .clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .portDataA(portDataA), .portDataB(portDataB), .portDirA(portDirA), .portDirB(portDirB),
  .padA(padA), .padAOen_n(padAOen_n), .padB(padB), .padBOen_n(padBOen_n));
`default_nettype wire

// [test/test_t16w_timer.sv]
// Purpose: self-checking bench for the timer
// Assumes: waitrequest answers every access
// Notes: duty is counted over whole periods so phase drops out
`timescale 1ns/1ps
`default_nettype none
module test_t16w_timer;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg  [4:0]  address = 5'h00;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg  [31:0] writedata = 32'h0;
  reg         portDataA = 1'b0;
  reg         portDataB = 1'b0;
  reg         portDirA = 1'b1;
  reg         portDirB = 1'b1;
  reg         extPin = 1'b0;
  reg         capPin = 1'b0;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        padA;
  wire        padAOen_n;
  wire        padB;
  wire        padBOen_n;
  integer     bad_count = 0;
  integer     checks_done = 0;
  integer     seed = 74012;
  integer     i;
  integer     h;
  reg  [31:0] rd;
  reg         waveA = 1'b0;
  reg         waveB = 1'b0;
  t16w_timer uut (
    .clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .extClockPin(extPin), .capturePin(capPin), .portDataA(portDataA), .portDataB(portDataB),
    .portDirA(portDirA), .portDirB(portDirB), .padA(padA), .padAOen_n(padAOen_n),
    .padB(padB), .padBOen_n(padBOen_n));
  // 100 MHz
  always #5 clk_sys = ~clk_sys;
  task check(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task busWr(input [4:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      write <= 1'b1;
      address <= a;
      writedata <= d;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      write <= 1'b0;
    end
  endtask
  task busRd(input [4:0] a);
    begin
      @(posedge clk_sys);
      read <= 1'b1;
      address <= a;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rd = readdata;
      read <= 1'b0;
    end
  endtask
  // one rising and one falling edge on the capture pin, each well past the synchroniser
  task pulseCap;
    begin
      capPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      capPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // non-pwm match action on the waveform bit
  function nextWave(input [1:0] c, input cur);
    nextWave = (c == 2'b00) ? cur : (c == 2'b01) ? !cur : c[0];
  endfunction
  // restart from zero in a mode, then count high cycles on pad a
  task pwmRun(input [1:0] lo, input [1:0] hi, input [15:0] cmp, input [1:0] com, input integer win,
              input integer exp);
    begin
      busWr(5'h04, 32'h0);
      busWr(5'h0c, {16'h0, cmp});
      busWr(5'h00, {24'h0, com, 4'h0, lo});
      busWr(5'h08, 32'h0);
      busWr(5'h04, {27'h0, hi, 3'h1});
      repeat (600) @(posedge clk_sys);
      h = 0;
      repeat (win) begin
        @(posedge clk_sys);
        if (padA === 1'b1) h = h + 1;
      end
      check(h, exp);
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    busRd(5'h00);
    check(rd, 32'h0);
    busRd(5'h04);
    check(rd, 32'h0);
    busRd(5'h1c);
    check(rd, 32'h0);
    // forced matches, first one hand-picked, clock stopped
    for (i = 0; i < 16; i = i + 1) begin
      rd = (i == 0) ? 32'h0000000b : $random(seed);
      portDataA <= rd[4];
      portDataB <= rd[5];
      portDirA <= rd[6];
      portDirB <= rd[7];
      busWr(5'h00, {24'h0, rd[1:0], rd[3:2], 4'hc});
      waveA = nextWave(rd[1:0], waveA);
      waveB = nextWave(rd[3:2], waveB);
      repeat (2) @(posedge clk_sys);
      check(padA, (rd[1:0] != 2'b00) ? waveA : rd[4]);
      check(padB, (rd[3:2] != 2'b00) ? waveB : rd[5]);
      check(padAOen_n, !rd[6]);
      check(padBOen_n, !rd[7]);
    end
    h = {rd[1:0], rd[3:2], 4'h0};
    busRd(5'h00);
    check(rd, h);
    busRd(5'h18);
    check(rd, 32'h0);
    // force in fast pwm is ignored; output mode picked so that a force would flip the bit
    busWr(5'h04, 32'h08);
    busWr(5'h00, waveA ? 32'h00000081 : 32'h000000c1);
    busWr(5'h00, waveA ? 32'h0000008d : 32'h000000cd);
    repeat (2) @(posedge clk_sys);
    check(padA, waveA);
    // match blocked after a count write, then normal match and overflow
    busWr(5'h04, 32'h0);
    busWr(5'h00, 32'h0);
    busWr(5'h0c, 32'h20);
    busWr(5'h10, 32'h30);
    busWr(5'h08, 32'h20);
    busWr(5'h18, 32'hf);
    busWr(5'h04, 32'h1);
    repeat (8) @(posedge clk_sys);
    busWr(5'h04, 32'h0);
    busRd(5'h18);
    check(rd, 32'h0);
    busWr(5'h04, 32'h1);
    repeat (20) @(posedge clk_sys);
    busWr(5'h04, 32'h0);
    busRd(5'h18);
    check(rd, 32'h2);
    busWr(5'h08, 32'hfff8);
    busWr(5'h18, 32'hf);
    busWr(5'h04, 32'h1);
    repeat (20) @(posedge clk_sys);
    busWr(5'h04, 32'h0);
    busRd(5'h18);
    check(rd, 32'h1);
    // external rising edges drive the count, a capture pin edge copies it
    busWr(5'h04, 32'h47);
    busWr(5'h08, 32'h100);
    busWr(5'h18, 32'hf);
    for (i = 0; i < 5; i = i + 1) begin
      extPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      extPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    pulseCap;
    busRd(5'h14);
    check(rd, 32'h105);
    busRd(5'h18);
    check(rd, 32'h8);
    // capture register as top: pin edges are ignored
    busWr(5'h04, 32'h58);
    busWr(5'h18, 32'hf);
    pulseCap;
    busRd(5'h18);
    check(rd, 32'h0);
    busRd(5'h14);
    check(rd, 32'h105);
    // waveform modes
    portDataA <= 1'b0;
    pwmRun(2'h1, 2'h1, 16'h0040, 2'h2, 512, 130);
    pwmRun(2'h1, 2'h1, 16'h0040, 2'h3, 512, 382);
    pwmRun(2'h1, 2'h1, 16'h00ff, 2'h2, 512, 512);
    pwmRun(2'h1, 2'h1, 16'h0040, 2'h1, 512, 0);
    pwmRun(2'h3, 2'h3, 16'h0040, 2'h1, 1300, 650);
    pwmRun(2'h1, 2'h0, 16'h0040, 2'h2, 1020, 256);
    pwmRun(2'h1, 2'h2, 16'h0040, 2'h1, 1280, 640);
    end_sim;
  end
  // hang guard, far beyond the expected run
  initial begin
    #500000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule
`default_nettype wire
